/* File: rtl/smbp_pkg.sv */
/*
 package for the two-wire master with boot probe: timing, control
 byte layout, probe codes and engine operations.
 assumes a 50 MHz system clock.
*/
package smbp_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int SCL_PERIOD_NS = 10000;
   localparam int QUARTER_CYC   = SCL_PERIOD_NS / CLK_PERIOD_NS / 4;

   // control byte fields
   localparam logic [3:0] EE_TYPE_NIBBLE = 4'ha;
   localparam logic [2:0] EE_SUB_ONE     = 3'h0;
   localparam logic [2:0] EE_SUB_TWO     = 3'h1;
   localparam logic       DIR_WRITE      = 1'b0;
   localparam logic       DIR_READ       = 1'b1;
   localparam logic [7:0] CTL_PROBE_ONE  = 8'ha1;
   localparam logic [7:0] CTL_PROBE_TWO  = 8'ha3;
   localparam logic [7:0] PTR_ZERO       = 8'h00;

   // first-byte codes and stored bytes
   localparam logic [7:0] HDR_ID_ONLY = 8'hb0;
   localparam logic [7:0] HDR_LOAD    = 8'hb2;
   localparam int         ID_BYTES    = 6;

   // probe result codes
   localparam logic [1:0] RES_NONE = 2'h0;
   localparam logic [1:0] RES_ONE  = 2'h1;
   localparam logic [1:0] RES_TWO  = 2'h2;

   typedef enum logic [1:0] {
      OP_START = 2'h0,
      OP_WRITE = 2'h1,
      OP_READ  = 2'h2,
      OP_STOP  = 2'h3
   } smbp_op_type;
endpackage

/* File: rtl/smbp_bit_engine.sv */
/*
 bit engine: start, stop and nine-clock byte transfers on open-drain
 clock and data lines, with clock stretching and contention check.
 assumes pin inputs asynchronous; synchronised here by two flops.
*/
module smbp_bit_engine #(
   parameter int QUARTER = smbp_pkg::QUARTER_CYC
) (
   input  wire logic               clock,
   input  wire logic               nrst,
   input  wire logic               op_valid,
   input  wire smbp_pkg::smbp_op_type op,
   input  wire logic [7:0]         tx,
   input  wire logic               nack,
   input  wire logic               scl_in,
   input  wire logic               sda_in,
   output logic                    scl_oe_n,
   output logic                    sda_oe_n,
   output logic                    done,
   output logic [7:0]              rx,
   output logic                    acked,
   output logic                    fault
);
   import smbp_pkg::*;

   if (QUARTER < 2) begin : g_bad_quarter
      $error("QUARTER must be at least 2");
   end

   typedef enum logic [1:0] {
      E_IDLE  = 2'h0,
      E_START = 2'h1,
      E_BIT   = 2'h2,
      E_STOP  = 2'h3
   } smbp_eng_type;

   localparam int CW = $clog2(QUARTER);

   smbp_eng_type st_r, st_nxt;
   smbp_op_type  op_r, op_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic [1:0]    ph_r, ph_nxt;
   logic [3:0]    bit_r, bit_nxt;
   logic [7:0]    sh_r, sh_nxt;
   logic          nack_r, nack_nxt;
   logic          ack_r, ack_nxt;
   logic          flt_r, flt_nxt;
   logic          done_r, done_nxt;
   logic          scl_oe_n_r, scl_oe_n_nxt;
   logic          sda_oe_n_r, sda_oe_n_nxt;
   logic          scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r;
   logic          bsda;
   logic [1:0]    lo;

   // line pattern {scl_low, sda_low} for a state and phase
   function automatic logic [1:0] pat(smbp_eng_type s, logic [1:0] p,
                                      logic [1:0] cur, logic b);
      logic [1:0] r;
      r = cur;
      unique case (s)
         E_START: r = (p == 2'h0) ? {cur[1], 1'b0} :
                      (p == 2'h1) ? 2'b00 :
                      (p == 2'h2) ? 2'b01 : 2'b11;
         E_BIT:   r = (p == 2'h0) ? {1'b1, b} :
                      (p == 2'h3) ? {1'b1, cur[0]} : {1'b0, b};
         E_STOP:  r = (p == 2'h0) ? 2'b11 :
                      (p == 2'h1) ? 2'b01 : 2'b00;
         E_IDLE:  r = cur;
      endcase
      return r;
   endfunction

   always_comb begin
      st_nxt = st_r;
      op_nxt = op_r;
      cnt_nxt = cnt_r;
      ph_nxt = ph_r;
      bit_nxt = bit_r;
      sh_nxt = sh_r;
      nack_nxt = nack_r;
      ack_nxt = ack_r;
      flt_nxt = flt_r;
      done_nxt = 1'b0;
      if (st_r == E_IDLE) begin
         cnt_nxt = '0;
         if (op_valid) begin
            st_nxt = (op == OP_START) ? E_START :
                     (op == OP_STOP) ? E_STOP : E_BIT;
            op_nxt = op;
            ph_nxt = 2'h0;
            bit_nxt = 4'h0;
            sh_nxt = tx;
            nack_nxt = nack;
            ack_nxt = 1'b0;
            flt_nxt = 1'b0;
         end
      end else if (scl_oe_n_r && !scl_s2_r) begin
         cnt_nxt = '0;  // slave holds the clock low
      end else if (cnt_r != CW'(QUARTER - 1)) begin
         cnt_nxt = cnt_r + 1'b1;
      end else begin
         cnt_nxt = '0;
         ph_nxt = ph_r + 2'h1;
         if (st_r == E_BIT && ph_r == 2'h2) begin
            if (bit_r == 4'h8) begin
               ack_nxt = !sda_s2_r;
            end else begin
               sh_nxt = {sh_r[6:0], sda_s2_r};
               // released a one yet line is low: contention
               if (op_r == OP_WRITE && sda_oe_n_r && !sda_s2_r) begin
                  flt_nxt = 1'b1;
                  st_nxt = E_IDLE;
                  done_nxt = 1'b1;
               end
            end
         end
         if (ph_r == 2'h3) begin
            if (st_r == E_BIT && bit_r != 4'h8) begin
               bit_nxt = bit_r + 4'h1;
            end else begin
               st_nxt = E_IDLE;
               done_nxt = 1'b1;
            end
         end
      end
      bsda = (bit_nxt == 4'h8) ? (op_nxt == OP_READ && !nack_nxt)
                               : (op_nxt == OP_WRITE && !sh_nxt[7]);
      lo = pat(st_nxt, ph_nxt, {!scl_oe_n_r, !sda_oe_n_r}, bsda);
      if (st_nxt == E_IDLE && flt_nxt) begin
         lo[0] = 1'b0;
      end
      scl_oe_n_nxt = !lo[1];
      sda_oe_n_nxt = !lo[0];
   end

   always_ff @(posedge clock) begin
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      if (!nrst) begin
         st_r <= E_IDLE;
         op_r <= OP_START;
         cnt_r <= '0;
         ph_r <= 2'h0;
         bit_r <= 4'h0;
         sh_r <= 8'h00;
         nack_r <= 1'b0;
         ack_r <= 1'b0;
         flt_r <= 1'b0;
         done_r <= 1'b0;
         scl_oe_n_r <= 1'b1;
         sda_oe_n_r <= 1'b1;
      end else begin
         st_r <= st_nxt;
         op_r <= op_nxt;
         cnt_r <= cnt_nxt;
         ph_r <= ph_nxt;
         bit_r <= bit_nxt;
         sh_r <= sh_nxt;
         nack_r <= nack_nxt;
         ack_r <= ack_nxt;
         flt_r <= flt_nxt;
         done_r <= done_nxt;
         scl_oe_n_r <= scl_oe_n_nxt;
         sda_oe_n_r <= sda_oe_n_nxt;
      end
   end

   assign scl_oe_n = scl_oe_n_r;
   assign sda_oe_n = sda_oe_n_r;
   assign done = done_r;
   assign rx = sh_r;
   assign acked = ack_r;
   assign fault = flt_r;
endmodule

/* File: rtl/smbp_master.sv */
/*
 two-wire master with processor byte interface and power-on boot probe.
 assumes processor strobes are one-cycle pulses on the same clock and
 that bus pins are open drain with external pull-ups.
*/
// Notes on behaviour
// - first buffer read clocks in first byte
// - each buffer read returns byte, starts next
// - final flag makes next reception not acknowledged
// - read with stop set starts no reception
// - byte done raises serial interrupt when enabled
// - boot probe runs after reset, reads first byte
// - pointer reset: write control, zero address bytes
// - one zero byte or two, by type
// - probe one: control 10100001, ack means one-byte
// - probe two: 10100011, no ack means none
// - first byte B0 or B2 valid; copy six
// - probe result: 00 none, 01 one, 10 two
module smbp_master #(
   parameter int LOAD_LEN = 16,
   parameter int AW       = 8,
   parameter int QUARTER  = smbp_pkg::QUARTER_CYC
) (
   input  wire logic            clock,
   input  wire logic            nrst,
   input  wire logic            set_start,
   input  wire logic            set_stop,
   input  wire logic            set_final_read,
   input  wire logic            buf_wr,
   input  wire logic [7:0]      buf_wdata,
   input  wire logic            buf_rd,
   input  wire logic            ctl_stat_rd,
   input  wire logic            irq_enable,
   input  wire logic            scl_in,
   input  wire logic            sda_in,
   output logic                 scl_out,
   output logic                 scl_oe_n,
   output logic                 sda_out,
   output logic                 sda_oe_n,
   output logic [7:0]           serial_byte_buffer,
   output logic                 start_flag,
   output logic                 stop_flag,
   output logic                 final_read_flag,
   output logic                 probe_result_hi,
   output logic                 probe_result_lo,
   output logic                 bus_fault_flag,
   output logic                 ack_flag,
   output logic                 done_flag,
   output logic                 serial_irq_line,
   output logic                 boot_busy,
   output logic [8*smbp_pkg::ID_BYTES-1:0] boot_id_bytes,
   output logic                 ram_we,
   output logic [AW-1:0]        ram_addr,
   output logic [7:0]           ram_data
);
   import smbp_pkg::*;

   localparam int LAST = ID_BYTES + LOAD_LEN;
   localparam int NW   = $clog2(LAST + 1);
   if (LOAD_LEN < 1 || LOAD_LEN > 2**AW) begin : g_bad_len
      $error("LOAD_LEN must be 1 to 2**AW");
   end

   typedef enum logic [3:0] {
      B_PSTART = 4'h0, B_PADDR  = 4'h1, B_PDUMMY = 4'h2, B_PSTOP = 4'h3,
      B_WSTART = 4'h4, B_WCTRL  = 4'h5, B_WZERO  = 4'h6, B_RSTART = 4'h7,
      B_RCTRL  = 4'h8, B_RDATA  = 4'h9, B_FSTOP  = 4'ha, B_DONE  = 4'hb
   } smbp_boot_type;
   typedef enum logic [1:0] {
      C_IDLE = 2'h0, C_START = 2'h1, C_BYTE = 2'h2, C_STOP = 2'h3
   } smbp_cpu_type;

   smbp_boot_type bst_r, bst_nxt;
   smbp_cpu_type  cst_r, cst_nxt;
   smbp_op_type   eop_r, eop_nxt;
   logic [7:0] etx_r, etx_nxt, rx_r, rx_nxt, hold_r, hold_nxt;
   logic [7:0] hdr_r, hdr_nxt, rdat_r, rdat_nxt;
   logic [NW-1:0] cnt_r, cnt_nxt;
   logic [AW-1:0] radr_r, radr_nxt;
   logic [1:0] res_r, res_nxt;
   logic [8*ID_BYTES-1:0] idb_r, idb_nxt;
   logic ev_r, ev_nxt, enk_r, enk_nxt, iss_r, iss_nxt;
   logic sub_r, sub_nxt, fnd_r, fnd_nxt, busy_r, busy_nxt;
   logic rwe_r, rwe_nxt;
   logic stf_r, stf_nxt, spf_r, spf_nxt, lf_r, lf_nxt;
   logic flt_r, flt_nxt, ack_r, ack_nxt, dn_r, dn_nxt, irq_r, irq_nxt;
   logic rdg_r, rdg_nxt, pend_r, pend_nxt, pa_r, pa_nxt, pf_r, pf_nxt;
   logic e_done, e_ack, e_flt;
   logic [7:0] e_rx;

   smbp_bit_engine #(.QUARTER(QUARTER)) u_eng (
      .clock    (clock),
      .nrst     (nrst),
      .op_valid (ev_r),
      .op       (eop_r),
      .tx       (etx_r),
      .nack     (enk_r),
      .scl_in   (scl_in),
      .sda_in   (sda_in),
      .scl_oe_n (scl_oe_n),
      .sda_oe_n (sda_oe_n),
      .done     (e_done),
      .rx       (e_rx),
      .acked    (e_ack),
      .fault    (e_flt)
   );

   function automatic smbp_op_type boot_op(smbp_boot_type s);
      unique case (s)
         B_PSTART, B_WSTART, B_RSTART: return OP_START;
         B_PDUMMY, B_RDATA:            return OP_READ;
         B_PSTOP, B_FSTOP, B_DONE:     return OP_STOP;
         default:                      return OP_WRITE;
      endcase
   endfunction

   always_comb begin
      bst_nxt = bst_r; cst_nxt = cst_r; eop_nxt = eop_r; etx_nxt = etx_r;
      rx_nxt = rx_r; hold_nxt = hold_r; hdr_nxt = hdr_r; cnt_nxt = cnt_r;
      radr_nxt = radr_r; rdat_nxt = rdat_r; res_nxt = res_r;
      idb_nxt = idb_r; ev_nxt = 1'b0; enk_nxt = enk_r; iss_nxt = iss_r;
      sub_nxt = sub_r; fnd_nxt = fnd_r; busy_nxt = busy_r; rwe_nxt = 1'b0;
      stf_nxt = stf_r; spf_nxt = spf_r; lf_nxt = lf_r; flt_nxt = flt_r;
      ack_nxt = ack_r; dn_nxt = dn_r; irq_nxt = irq_r; rdg_nxt = rdg_r;
      pend_nxt = pend_r; pa_nxt = pa_r; pf_nxt = pf_r;
      if (bst_r != B_DONE) begin
         if (!iss_r) begin  // issue this step's bus operation
            ev_nxt = 1'b1;
            iss_nxt = 1'b1;
            eop_nxt = boot_op(bst_r);
            enk_nxt = (bst_r == B_PDUMMY) ||
                      (cnt_r == NW'(hdr_r == HDR_LOAD ? LAST : ID_BYTES));
            etx_nxt = (bst_r == B_WZERO) ? PTR_ZERO :
                      {EE_TYPE_NIBBLE, sub_r ? EE_SUB_TWO : EE_SUB_ONE,
                       (bst_r == B_WCTRL) ? DIR_WRITE : DIR_READ};
         end else if (e_done) begin
            iss_nxt = 1'b0;
            unique case (bst_r)
               B_PSTART: bst_nxt = B_PADDR;
               B_PADDR: begin
                  fnd_nxt = e_ack;
                  bst_nxt = e_ack ? B_PDUMMY : B_PSTOP;
               end
               B_PDUMMY: bst_nxt = B_PSTOP;  // data discarded
               B_PSTOP: begin
                  if (fnd_r) bst_nxt = B_WSTART;
                  else if (!sub_r) begin
                     sub_nxt = 1'b1;
                     bst_nxt = B_PSTART;
                  end else bst_nxt = B_FSTOP;
               end
               B_WSTART: bst_nxt = B_WCTRL;
               B_WCTRL: begin
                  cnt_nxt = '0;
                  bst_nxt = e_ack ? B_WZERO : B_FSTOP;
               end
               B_WZERO: begin  // one or two zero bytes
                  cnt_nxt = cnt_r + 1'b1;
                  if (cnt_r == NW'(sub_r)) bst_nxt = B_RSTART;
               end
               B_RSTART: bst_nxt = B_RCTRL;
               B_RCTRL: begin
                  cnt_nxt = '0;
                  bst_nxt = e_ack ? B_RDATA : B_FSTOP;
               end
               B_RDATA: begin
                  cnt_nxt = cnt_r + 1'b1;
                  if (cnt_r == '0) begin
                     hdr_nxt = e_rx;
                     if (e_rx == HDR_ID_ONLY || e_rx == HDR_LOAD)
                        res_nxt = sub_r ? RES_TWO : RES_ONE;
                     else bst_nxt = B_FSTOP;
                  end else if (cnt_r <= NW'(ID_BYTES)) begin
                     idb_nxt = {idb_r[8*ID_BYTES-9:0], e_rx};
                  end else begin
                     rwe_nxt = 1'b1;
                     radr_nxt = AW'(cnt_r - NW'(ID_BYTES + 1));
                     rdat_nxt = e_rx;
                  end
                  if (e_flt || cnt_r == NW'(hdr_r == HDR_LOAD ? LAST
                                                         : ID_BYTES))
                     bst_nxt = B_FSTOP;
               end
               B_FSTOP: begin
                  bst_nxt = B_DONE;
                  busy_nxt = 1'b0;
               end
               default: bst_nxt = B_DONE;
            endcase
         end
      end else begin
         if (ctl_stat_rd) irq_nxt = 1'b0;
         if (buf_wr || buf_rd) begin
            dn_nxt = 1'b0;
            flt_nxt = 1'b0;
            irq_nxt = 1'b0;
         end
         if (set_start) stf_nxt = 1'b1;
         if (set_final_read) lf_nxt = 1'b1;
         if (set_stop) spf_nxt = 1'b1;
         unique case (cst_r)
            C_IDLE: begin
               if (buf_wr) begin
                  ev_nxt = 1'b1;
                  hold_nxt = buf_wdata;
                  etx_nxt = buf_wdata;
                  if (stf_r) begin
                     rdg_nxt = buf_wdata[0];
                     eop_nxt = OP_START;
                     cst_nxt = C_START;
                  end else begin
                     eop_nxt = OP_WRITE;
                     cst_nxt = C_BYTE;
                  end
               end else if (buf_rd && rdg_r && !spf_r) begin
                  ev_nxt = 1'b1;
                  eop_nxt = OP_READ;
                  enk_nxt = lf_r;
                  cst_nxt = C_BYTE;
               end else if (spf_r) begin
                  ev_nxt = 1'b1;
                  eop_nxt = OP_STOP;
                  pend_nxt = 1'b0;
                  cst_nxt = C_STOP;
               end
            end
            C_START: if (e_done) begin
               ev_nxt = 1'b1;
               eop_nxt = OP_WRITE;
               etx_nxt = hold_r;
               cst_nxt = C_BYTE;
            end
            C_BYTE: if (e_done) begin
               stf_nxt = set_start;
               lf_nxt = set_final_read;
               if (eop_r == OP_READ) rx_nxt = e_rx;
               if (spf_r || set_stop) begin  // status waits for stop
                  pend_nxt = 1'b1;
                  pa_nxt = e_ack;
                  pf_nxt = e_flt;
                  ev_nxt = 1'b1;
                  eop_nxt = OP_STOP;
                  cst_nxt = C_STOP;
               end else begin
                  dn_nxt = 1'b1;
                  ack_nxt = e_ack;
                  flt_nxt = e_flt;
                  if (irq_enable) irq_nxt = 1'b1;
                  cst_nxt = C_IDLE;
               end
            end
            C_STOP: if (e_done) begin
               spf_nxt = 1'b0;
               rdg_nxt = 1'b0;
               cst_nxt = C_IDLE;
               if (pend_r) begin
                  dn_nxt = 1'b1;
                  ack_nxt = pa_r;
                  flt_nxt = pf_r;
                  if (irq_enable) irq_nxt = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         bst_r <= B_PSTART; cst_r <= C_IDLE; eop_r <= OP_START;
         etx_r <= 8'h00; rx_r <= 8'h00; hold_r <= 8'h00; hdr_r <= 8'h00;
         cnt_r <= '0; radr_r <= '0; rdat_r <= 8'h00; res_r <= RES_NONE;
         idb_r <= '0; ev_r <= 1'b0; enk_r <= 1'b0; iss_r <= 1'b0;
         sub_r <= 1'b0; fnd_r <= 1'b0; busy_r <= 1'b1; rwe_r <= 1'b0;
         stf_r <= 1'b0; spf_r <= 1'b0; lf_r <= 1'b0; flt_r <= 1'b0;
         ack_r <= 1'b0; dn_r <= 1'b0; irq_r <= 1'b0; rdg_r <= 1'b0;
         pend_r <= 1'b0; pa_r <= 1'b0; pf_r <= 1'b0;
      end else begin
         bst_r <= bst_nxt; cst_r <= cst_nxt; eop_r <= eop_nxt;
         etx_r <= etx_nxt; rx_r <= rx_nxt; hold_r <= hold_nxt;
         hdr_r <= hdr_nxt; cnt_r <= cnt_nxt; radr_r <= radr_nxt;
         rdat_r <= rdat_nxt; res_r <= res_nxt; idb_r <= idb_nxt;
         ev_r <= ev_nxt; enk_r <= enk_nxt; iss_r <= iss_nxt;
         sub_r <= sub_nxt; fnd_r <= fnd_nxt; busy_r <= busy_nxt;
         rwe_r <= rwe_nxt; stf_r <= stf_nxt; spf_r <= spf_nxt;
         lf_r <= lf_nxt; flt_r <= flt_nxt; ack_r <= ack_nxt;
         dn_r <= dn_nxt; irq_r <= irq_nxt; rdg_r <= rdg_nxt;
         pend_r <= pend_nxt; pa_r <= pa_nxt; pf_r <= pf_nxt;
      end
   end

   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign serial_byte_buffer = rx_r;
   assign start_flag = stf_r;
   assign stop_flag = spf_r;
   assign final_read_flag = lf_r;
   assign probe_result_hi = res_r[1];
   assign probe_result_lo = res_r[0];
   assign bus_fault_flag = flt_r;
   assign ack_flag = ack_r;
   assign done_flag = dn_r;
   assign serial_irq_line = irq_r;
   assign boot_busy = busy_r;
   assign boot_id_bytes = idb_r;
   assign ram_we = rwe_r;
   assign ram_addr = radr_r;
   assign ram_data = rdat_r;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   logic cpu_rd_go;
   assign cpu_rd_go = bst_r == B_DONE && cst_r == C_IDLE && !buf_wr &&
                      buf_rd && rdg_r && !spf_r;

   a_read_starts_rx: assert property (cpu_rd_go |=> ev_r &&
      eop_r == OP_READ ##1 u_eng.st_r != 2'h0)
      else $error("buffer read did not start a reception");
   a_final_nack: assert property (cpu_rd_go |=> enk_r == $past(lf_r))
      else $error("final read flag not passed to acknowledge bit");
   a_stop_no_read: assert property (bst_r == B_DONE && buf_rd && spf_r
      |=> !(ev_r && eop_r == OP_READ))
      else $error("read with stop pending started a reception");
   a_irq_on_done: assert property (bst_r == B_DONE && cst_r == C_BYTE &&
      e_done && !spf_r && !set_stop && irq_enable |=> dn_r && irq_r)
      else $error("byte done did not raise interrupt");
   a_boot_after_rst: assert property (!$past(nrst) |-> busy_r &&
      bst_r == B_PSTART ##[1:2] ev_r && eop_r == OP_START)
      else $error("boot probe did not start after reset");
   a_probe_one_ctl: assert property (ev_r && bst_r == B_PADDR && !sub_r
      |-> etx_r == CTL_PROBE_ONE)
      else $error("first probe control byte wrong");
   a_probe_two_ctl: assert property (ev_r && bst_r == B_PADDR && sub_r
      |-> etx_r == CTL_PROBE_TWO)
      else $error("second probe control byte wrong");
   a_zero_ptr: assert property (ev_r && bst_r == B_WZERO
      |-> etx_r == PTR_ZERO && cnt_r <= NW'(sub_r))
      else $error("pointer reset byte wrong");
   a_bad_header: assert property (bst_r == B_RDATA && e_done && iss_r &&
      cnt_r == '0 && e_rx != HDR_ID_ONLY && e_rx != HDR_LOAD
      |=> res_r == RES_NONE && bst_r == B_FSTOP)
      else $error("invalid first byte accepted");
   a_result_code: assert property (res_r != 2'h3 &&
      (bst_r != B_DONE || res_r != RES_TWO || sub_r))
      else $error("probe result code illegal");
   c_boot_one: cover property (bst_r == B_FSTOP ##1 res_r == RES_ONE);
   c_boot_two: cover property (rwe_r && res_r == RES_TWO);
   c_cpu_read: cover property (cpu_rd_go ##[1:1000] dn_r);
   c_irq: cover property ($rose(irq_r));
endmodule

/* File: testbench/smbp_ee_model.sv */
/*
 two-wire memory model strapped to one sub-address, two address bytes.
 assumes open-drain lines resolved by the bench with pull-ups.
*/
module smbp_ee_model #(
   parameter logic [2:0] SUB = 3'h1
) (
   input  wire logic scl,
   input  wire logic sda,
   output logic      sda_low
);
   timeunit 1ns;
   timeprecision 1ns;
   import smbp_pkg::*;
   logic [7:0] mem [256];
   logic [7:0] sh = 8'h00;
   logic [7:0] ptr = 8'h55;
   logic       act = 1'b0;
   logic       rd, sel, mnack;
   int         bi, nb, wa;
   initial begin
      sda_low = 1'b0;
      for (int i = 0; i < 256; i++) mem[i] = 8'(8'h40 + i);
      mem[0] = HDR_LOAD;
   end
   always @(negedge sda) if (scl) begin
      act = 1'b1;
      bi = -1;
      nb = 0;
      mnack = 1'b0;
   end
   always @(posedge sda) if (scl) act = 1'b0;
   always @(posedge scl) if (act) begin
      if (bi < 8) sh = {sh[6:0], sda};
      else if (rd && nb > 0) mnack = sda;
   end
   always @(negedge scl) if (act) begin
      if (bi == 8) begin
         bi = 0;
         nb++;
         if (rd && nb > 1) ptr++;
      end else bi++;
      sda_low = 1'b0;
      if (bi == 8 && !(rd && nb > 0)) begin
         if (nb == 0) begin
            sel = sh[7:1] == {EE_TYPE_NIBBLE, SUB};
            rd = sh[0];
            wa = 0;
         end else if (sel) begin
            // pointer valid only once both address bytes arrived
            if (wa < 2) ptr = wa == 1 ? sh : 8'h55;
            else mem[ptr++] = sh;
            wa++;
         end
         sda_low = sel;
      end
      if (sel && rd && nb > 0 && bi < 8 && !mnack) sda_low = !mem[ptr][7 - bi];
   end
endmodule

/* File: testbench/testbench.sv */
/*
 bench: boot probe, processor write, read-back and refused address.
 assumes pull-ups on both lines and the model at sub-address one.
*/
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import smbp_pkg::*;
   logic clock = 1'b0;
   logic nrst, buf_wr, buf_rd, set_start, set_stop, set_final_read;
   logic ctl_stat_rd, irq_enable, sda_low, scl_oe_n, sda_oe_n, ram_we;
   logic done_flag, ack_flag, stop_flag, bus_fault_flag, serial_irq_line;
   logic probe_result_hi, probe_result_lo, boot_busy;
   logic start_flag, final_read_flag;
   logic [5:0] strb;
   logic [7:0] buf_wdata, serial_byte_buffer, ram_addr, ram_data;
   logic [7:0] wd [5] = '{8'ha2, 8'h00, 8'h09, 8'h77, 8'h66};
   logic [47:0] boot_id_bytes;
   int errors, n_compared, cyc, n_ram, n_scl, n0;
   wire scl_in = scl_oe_n;
   wire sda_in = sda_oe_n & !sda_low;
   assign {set_start, set_stop, set_final_read, buf_wr, buf_rd,
           ctl_stat_rd} = strb;
   smbp_master #(.LOAD_LEN(2), .QUARTER(2)) u_dut (
      .clock, .nrst, .set_start, .set_stop, .set_final_read, .buf_wr,
      .buf_wdata, .buf_rd, .ctl_stat_rd, .irq_enable, .scl_in, .sda_in,
      .scl_out(), .scl_oe_n, .sda_out(), .sda_oe_n, .serial_byte_buffer,
      .start_flag, .stop_flag, .final_read_flag, .probe_result_hi,
      .probe_result_lo, .bus_fault_flag, .ack_flag, .done_flag,
      .serial_irq_line, .boot_busy, .boot_id_bytes, .ram_we, .ram_addr,
      .ram_data);
   smbp_ee_model u_ee (.scl(scl_in), .sda(sda_in), .sda_low);
   task automatic check(input logic [47:0] seen, exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic op(input logic [5:0] m, input logic [7:0] d);
      @(posedge clock);
      strb <= m;
      buf_wdata <= d;
      @(posedge clock);
      strb <= 6'h00;
      // let the strobe's effect reach the flags before they are read
      @(posedge clock);
   endtask
   task automatic xfer(input logic [5:0] m, input logic [7:0] d);
      op(m, d);
      for (int i = 0; i < 300 && done_flag !== 1'b1; i++) @(posedge clock);
   endtask
   task automatic stop;
      op(6'h10, 8'h00);
      for (int i = 0; i < 200 && stop_flag !== 1'b0; i++) @(posedge clock);
      check(stop_flag, 0, "stop_flag");
   endtask
   initial forever #10 clock = ~clock;
   always @(negedge scl_in) n_scl++;
   always @(posedge clock) if (++cyc == 20000) begin
      errors++;
      report_and_stop;
   end
   always @(posedge clock) if (ram_we === 1'b1) begin
      check({ram_addr, ram_data}, {n_ram[7:0], 8'(8'h47 + n_ram)}, "ram");
      n_ram++;
   end
   initial begin
      strb = 6'h00;
      buf_wdata = 8'h00;
      irq_enable = 1'b1;
      nrst = 1'b0;
      repeat (10) @(posedge clock);
      nrst <= 1'b1;
      for (int i = 0; i < 5000 && boot_busy !== 1'b0; i++) @(posedge clock);
      check({probe_result_hi, probe_result_lo}, RES_TWO, "probe");
      check(boot_id_bytes, 48'h4142_4344_4546, "id");
      check(n_ram, 2, "ram count");
      op(6'h20, 8'h00);
      check(start_flag, 1, "start flag");
      for (int i = 0; i < 5; i++) begin
         xfer(6'h04, wd[i]);
         check(ack_flag, 1, "ack");
      end
      check(serial_irq_line, 1, "irq");
      check(start_flag, 0, "start clear");
      op(6'h01, 8'h00);
      check(serial_irq_line, 0, "irq clear");
      stop;
      op(6'h20, 8'h00);
      for (int i = 0; i < 3; i++) xfer(6'h04, wd[i]);
      op(6'h20, 8'h00);
      xfer(6'h04, 8'ha3);
      check(ack_flag, 1, "read address");
      xfer(6'h02, 8'h00);
      check(serial_byte_buffer, 8'h77, "byte 1");
      xfer(6'h02, 8'h00);
      check(serial_byte_buffer, 8'h66, "byte 2");
      op(6'h08, 8'h00);
      check(final_read_flag, 1, "final flag");
      xfer(6'h02, 8'h00);
      check({serial_byte_buffer, u_ee.mnack}, {8'h4b, 1'b1}, "byte 3");
      check(final_read_flag, 0, "final clear");
      n0 = n_scl;
      @(posedge clock);
      strb <= 6'h10;
      @(posedge clock);
      strb <= 6'h02;
      @(posedge clock);
      strb <= 6'h00;
      repeat (200) @(posedge clock);
      check(n_scl - n0, 0, "extra clocks");
      check({serial_byte_buffer, stop_flag}, {8'h4b, 1'b0}, "last");
      irq_enable <= 1'b0;
      op(6'h20, 8'h00);
      xfer(6'h04, 8'hae);
      check({ack_flag, serial_irq_line, bus_fault_flag}, 0, "refused");
      stop;
      report_and_stop;
   end
endmodule
